// File: hw/wrsp_core.sv
`timescale 1ns/10ps
// Behaviour
// - Short operand bit 3 picks working pointer zero (0) or one (1).
// - Chosen pointer's upper five bits form address bits 7 to 3.
// - Operand's three low bits form address bits 2 to 0.
// - Long operand with upper nibble 1100 decodes its low nibble as short.
// - In tagged long addressing, bit 3 picks the working pointer.
// - Push decrements the stack pointer first, then writes at the new address.
// - Pop reads at the current stack pointer, then increments it.
// - Stack pointer always addresses the most recently pushed byte.
// - Call pushes the program counter; return pops it back.
// - Interrupt pushes program counter and flags; interrupt return pops both.
// - Stack pointer is 16 bits: high byte at D8, low byte at D9.
// - Stack pointer is not initialised by reset.
// - Wrap of the low byte carries or borrows into the high byte.
// - User push and pop, incrementing and decrementing, on any register stack.
// - Working pointer zero sits at D6, working pointer one at D7.
// - After reset the pointers select slices C0-C7 and C8-CF.
module wrsp_core (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [9:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	input  wire logic [3:0]            opnd_short_i,
	input  wire logic [7:0]            opnd_long_i,
	output logic      [7:0]            short_addr_o,
	output logic      [7:0]            long_addr_o,
	input  wire wrsp_pkg::wrsp_cmd_t   stk_cmd_i,
	input  wire logic [7:0]            stk_data_i,
	input  wire logic [15:0]           pc_i,
	input  wire logic [7:0]            flags_i,
	input  wire logic [7:0]            user_ptr_i,
	input  wire logic [7:0]            rf_rdata_i,
	output logic                       rf_we_o,
	output logic                       rf_re_o,
	output logic      [15:0]           rf_addr_o,
	output logic      [7:0]            rf_wdata_o,
	output logic                       stk_busy_o,
	output logic                       stk_done_o,
	output logic      [7:0]            pop_data_o,
	output logic      [15:0]           pc_o,
	output logic      [7:0]            flags_o,
	output logic      [7:0]            user_ptr_o
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic wrsp_pkg::wrsp_slot_t slot_of(input wrsp_pkg::wrsp_cmd_t c, input logic [1:0] i);
		wrsp_pkg::wrsp_slot_t s;
		s = wrsp_pkg::SLOT_DATA;
		unique case (c)
			wrsp_pkg::CMD_CALL: s = (i == 2'd0) ? wrsp_pkg::SLOT_PC_LO : wrsp_pkg::SLOT_PC_HI;
			wrsp_pkg::CMD_RET:  s = (i == 2'd0) ? wrsp_pkg::SLOT_PC_HI : wrsp_pkg::SLOT_PC_LO;
			wrsp_pkg::CMD_INT:  s = (i == 2'd0) ? wrsp_pkg::SLOT_PC_LO :
			                        (i == 2'd1) ? wrsp_pkg::SLOT_PC_HI : wrsp_pkg::SLOT_FLAGS;
			wrsp_pkg::CMD_INTERRUPT_RETURN_INSTR: s = (i == 2'd0) ? wrsp_pkg::SLOT_FLAGS :
			                        (i == 2'd1) ? wrsp_pkg::SLOT_PC_HI : wrsp_pkg::SLOT_PC_LO;
			default:            s = wrsp_pkg::SLOT_DATA;
		endcase
		return s;
	endfunction : slot_of

	function automatic logic [1:0] last_of(input wrsp_pkg::wrsp_cmd_t c);
		unique case (c)
			wrsp_pkg::CMD_CALL, wrsp_pkg::CMD_RET:  return 2'd1;
			wrsp_pkg::CMD_INT, wrsp_pkg::CMD_INTERRUPT_RETURN_INSTR:  return 2'd2;
			default:                                return 2'd0;
		endcase
	endfunction : last_of

	function automatic logic is_pop(input wrsp_pkg::wrsp_cmd_t c);
		return (c == wrsp_pkg::CMD_POP) || (c == wrsp_pkg::CMD_RET) || (c == wrsp_pkg::CMD_INTERRUPT_RETURN_INSTR) ||
		       (c == wrsp_pkg::CMD_UPOP_INC) || (c == wrsp_pkg::CMD_UPOP_DEC);
	endfunction : is_pop

	function automatic logic is_user(input wrsp_pkg::wrsp_cmd_t c);
		return (c == wrsp_pkg::CMD_UPUSH_INC) || (c == wrsp_pkg::CMD_UPUSH_DEC) ||
		       (c == wrsp_pkg::CMD_UPOP_INC) || (c == wrsp_pkg::CMD_UPOP_DEC);
	endfunction : is_user

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum logic [1:0] {S_IDLE, S_PUSH, S_POP_RD, S_POP_CAP} wrsp_state_t;

	wrsp_state_t         state_r;
	wrsp_pkg::wrsp_cmd_t cmd_r;
	logic [1:0]          idx_r;
	logic [7:0]          wp0_r;
	logic [7:0]          wp1_r;
	logic [7:0]          sph_r;
	logic [7:0]          spl_r;
	logic [7:0]          uptr_r;
	logic [15:0]         sv_pc_r;
	logic [7:0]          sv_flags_r;
	logic [15:0]         sp_nxt;
	logic [7:0]          uptr_nxt;
	logic [15:0]         cur_ptr;
	logic [15:0]         step_ptr;
	logic                step_up;
	logic                last;
	logic                stepping;
	logic                accept;
	logic                bus_wr;
	logic [7:0]          bus_idx;
	logic [7:0]          short_nxt;
	logic [7:0]          long_nxt;
	logic [7:0]          push_byte;
	wrsp_pkg::wrsp_slot_t slot;

	assign accept   = (state_r == S_IDLE) && (stk_cmd_i != wrsp_pkg::CMD_NONE);
	assign last     = (idx_r == last_of(cmd_r));
	assign stepping = (state_r == S_PUSH) || (state_r == S_POP_CAP);
	assign slot     = slot_of(cmd_r, idx_r);
	assign step_up  = (cmd_r == wrsp_pkg::CMD_UPUSH_INC) || (cmd_r == wrsp_pkg::CMD_UPOP_INC) ||
	                  ((cmd_r != wrsp_pkg::CMD_UPOP_DEC) && is_pop(cmd_r) && !is_user(cmd_r));
	assign cur_ptr  = is_user(cmd_r) ? {8'h00, uptr_r} : {sph_r, spl_r};
	assign step_ptr = is_user(cmd_r) ? {8'h00, uptr_nxt} : sp_nxt;
	assign bus_idx  = wb_adr_i[wrsp_pkg::WB_IDX_LSB +: 8];
	assign bus_wr   = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];

	always_comb begin
		unique case (slot)
			wrsp_pkg::SLOT_PC_LO: push_byte = sv_pc_r[7:0];
			wrsp_pkg::SLOT_PC_HI: push_byte = sv_pc_r[15:8];
			wrsp_pkg::SLOT_FLAGS: push_byte = sv_flags_r;
			wrsp_pkg::SLOT_DATA:  push_byte = stk_data_i;
		endcase
	end

	// ------------------------------------------------------------
	// Pointer arithmetic and address forming
	// ------------------------------------------------------------
	wrsp_ptr_step #(.W(16)) u_sp_step (
		.val_i (cur_ptr),
		.inc_i (step_up),
		.val_o (sp_nxt)
	);

	wrsp_ptr_step #(.W(8)) u_up_step (
		.val_i (uptr_r),
		.inc_i (step_up),
		.val_o (uptr_nxt)
	);

	wrsp_addr_form u_short_form (
		.wp0_i  (wp0_r),
		.wp1_i  (wp1_r),
		.opnd_i ({4'h0, opnd_short_i}),
		.long_i (1'b0),
		.addr_o (short_nxt)
	);

	wrsp_addr_form u_long_form (
		.wp0_i  (wp0_r),
		.wp1_i  (wp1_r),
		.opnd_i (opnd_long_i),
		.long_i (1'b1),
		.addr_o (long_nxt)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			short_addr_o <= 8'h00;
			long_addr_o  <= 8'h00;
		end else begin
			short_addr_o <= short_nxt;
			long_addr_o  <= long_nxt;
		end
	end

	// ------------------------------------------------------------
	// Working pointers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wp0_r <= wrsp_pkg::WP0_RST;
			wp1_r <= wrsp_pkg::WP1_RST;
		end else if (bus_wr) begin
			if (bus_idx == wrsp_pkg::IDX_WP0) begin
				wp0_r <= wb_dat_i[7:0];
			end
			if (bus_idx == wrsp_pkg::IDX_WP1) begin
				wp1_r <= wb_dat_i[7:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Stack pointer, no reset on purpose
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (stepping && !is_user(cmd_r)) begin
			{sph_r, spl_r} <= sp_nxt;
		end else if (bus_wr && !rst_i) begin
			if (bus_idx == wrsp_pkg::IDX_SPH) begin
				sph_r <= wb_dat_i[7:0];
			end
			if (bus_idx == wrsp_pkg::IDX_SPL) begin
				spl_r <= wb_dat_i[7:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Stack sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r    <= S_IDLE;
			cmd_r      <= wrsp_pkg::CMD_NONE;
			idx_r      <= 2'd0;
			uptr_r     <= 8'h00;
			sv_pc_r    <= 16'h0000;
			sv_flags_r <= 8'h00;
		end else begin
			unique case (state_r)
				S_IDLE: begin
					if (accept) begin
						cmd_r      <= stk_cmd_i;
						idx_r      <= 2'd0;
						uptr_r     <= user_ptr_i;
						sv_pc_r    <= pc_i;
						sv_flags_r <= flags_i;
						state_r    <= is_pop(stk_cmd_i) ? S_POP_RD : S_PUSH;
					end
				end
				S_PUSH: begin
					if (is_user(cmd_r)) begin
						uptr_r <= uptr_nxt;
					end
					idx_r   <= idx_r + 2'd1;
					state_r <= last ? S_IDLE : S_PUSH;
				end
				S_POP_RD: begin
					state_r <= S_POP_CAP;
				end
				S_POP_CAP: begin
					if (is_user(cmd_r)) begin
						uptr_r <= uptr_nxt;
					end
					idx_r   <= idx_r + 2'd1;
					state_r <= last ? S_IDLE : S_POP_RD;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Register file port
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rf_we_o    <= 1'b0;
			rf_re_o    <= 1'b0;
			rf_addr_o  <= 16'h0000;
			rf_wdata_o <= 8'h00;
		end else begin
			rf_we_o <= (state_r == S_PUSH);
			rf_re_o <= (state_r == S_POP_RD);
			if (state_r == S_PUSH) begin
				rf_addr_o  <= step_ptr;
				rf_wdata_o <= push_byte;
			end else if (state_r == S_POP_RD) begin
				rf_addr_o <= cur_ptr;
			end
		end
	end

	// ------------------------------------------------------------
	// Popped data and handshake
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pop_data_o <= 8'h00;
			pc_o       <= 16'h0000;
			flags_o    <= 8'h00;
		end else if (state_r == S_POP_CAP) begin
			unique case (slot)
				wrsp_pkg::SLOT_PC_HI: pc_o[15:8] <= rf_rdata_i;
				wrsp_pkg::SLOT_PC_LO: pc_o[7:0]  <= rf_rdata_i;
				wrsp_pkg::SLOT_FLAGS: flags_o    <= rf_rdata_i;
				wrsp_pkg::SLOT_DATA:  pop_data_o <= rf_rdata_i;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stk_busy_o <= 1'b0;
			stk_done_o <= 1'b0;
			user_ptr_o <= 8'h00;
		end else begin
			stk_done_o <= stepping && last;
			user_ptr_o <= uptr_r;
			if (accept) begin
				stk_busy_o <= 1'b1;
			end else if (stepping && last) begin
				stk_busy_o <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			unique case (bus_idx)
				wrsp_pkg::IDX_WP0: wb_dat_o <= {24'h00_0000, wp0_r};
				wrsp_pkg::IDX_WP1: wb_dat_o <= {24'h00_0000, wp1_r};
				wrsp_pkg::IDX_SPH: wb_dat_o <= {24'h00_0000, sph_r};
				wrsp_pkg::IDX_SPL: wb_dat_o <= {24'h00_0000, spl_r};
				default:           wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_short_wp0;
		@(posedge clk_i) disable iff (rst_i)
		!rst_i && !opnd_short_i[3] |=> short_addr_o[7:3] == $past(wp0_r[7:3]);
	endproperty
	a_short_wp0: assert property (p_short_wp0) else $error("short operand did not use pointer zero");

	property p_short_wp1;
		@(posedge clk_i) disable iff (rst_i)
		!rst_i && opnd_short_i[3] |=> short_addr_o[7:3] == $past(wp1_r[7:3]);
	endproperty
	a_short_wp1: assert property (p_short_wp1) else $error("short operand did not use pointer one");

	property p_short_low;
		@(posedge clk_i) disable iff (rst_i)
		!rst_i |=> short_addr_o[2:0] == $past(opnd_short_i[2:0]);
	endproperty
	a_short_low: assert property (p_short_low) else $error("short address low bits wrong");

	property p_long_tag;
		@(posedge clk_i) disable iff (rst_i)
		!rst_i && (opnd_long_i[7:4] == wrsp_pkg::TAG_WORKING) |=>
			long_addr_o == {($past(opnd_long_i[3]) ? $past(wp1_r[7:3]) : $past(wp0_r[7:3])),
			                $past(opnd_long_i[2:0])};
	endproperty
	a_long_tag: assert property (p_long_tag) else $error("tagged long operand decoded wrongly");

	property p_long_direct;
		@(posedge clk_i) disable iff (rst_i)
		!rst_i && (opnd_long_i[7:4] != wrsp_pkg::TAG_WORKING) |=> long_addr_o == $past(opnd_long_i);
	endproperty
	a_long_direct: assert property (p_long_direct) else $error("direct long operand altered");

	property p_push_dec;
		@(posedge clk_i) disable iff (rst_i)
		(state_r == S_PUSH && cmd_r == wrsp_pkg::CMD_PUSH) |=>
			rf_we_o && ({sph_r, spl_r} == $past(cur_ptr) - 16'h0001) && (rf_addr_o == {sph_r, spl_r});
	endproperty
	a_push_dec: assert property (p_push_dec) else $error("push did not write at decremented pointer");

	property p_pop_inc;
		@(posedge clk_i) disable iff (rst_i)
		(state_r == S_POP_CAP && cmd_r == wrsp_pkg::CMD_POP) |->
			rf_re_o ##1 ({sph_r, spl_r} == $past(rf_addr_o) + 16'h0001);
	endproperty
	a_pop_inc: assert property (p_pop_inc) else $error("pop did not read then increment");

	property p_wp_reset;
		@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |-> (wp0_r == wrsp_pkg::WP0_RST) && (wp1_r == wrsp_pkg::WP1_RST);
	endproperty
	a_wp_reset: assert property (p_wp_reset) else $error("working pointers wrong after reset");

	property p_int_frame;
		@(posedge clk_i) disable iff (rst_i)
		(state_r == S_IDLE && stk_cmd_i == wrsp_pkg::CMD_INT) |->
			##2 rf_we_o ##1 rf_we_o ##1 (rf_we_o && stk_done_o && rf_wdata_o == $past(flags_i, 4));
	endproperty
	a_int_frame: assert property (p_int_frame) else $error("interrupt frame wrong");

endmodule : wrsp_core

// File: shared/wrsp_pkg.sv
package wrsp_pkg;

	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_WP0  = 8'hD6;
	localparam logic [7:0] IDX_WP1  = 8'hD7;
	localparam logic [7:0] IDX_SPH  = 8'hD8;
	localparam logic [7:0] IDX_SPL  = 8'hD9;
	localparam int         WB_ADR_W = 10;
	localparam int         WB_IDX_LSB = 2;

	// ------------------------------------------------------------
	// Reset values and field layout
	// ------------------------------------------------------------
	localparam logic [7:0] WP0_RST     = 8'hC0;
	localparam logic [7:0] WP1_RST     = 8'hC8;
	localparam logic [3:0] TAG_WORKING = 4'hC;
	localparam int         SEL_BIT     = 3;
	localparam int         SLICE_LSB   = 3;

	// ------------------------------------------------------------
	// Stack commands and byte slots
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		CMD_NONE,
		CMD_PUSH,
		CMD_POP,
		CMD_CALL,
		CMD_RET,
		CMD_INT,
		CMD_INTERRUPT_RETURN_INSTR,
		CMD_UPUSH_INC,
		CMD_UPUSH_DEC,
		CMD_UPOP_INC,
		CMD_UPOP_DEC
	} wrsp_cmd_t;

	typedef enum logic [1:0] {
		SLOT_DATA,
		SLOT_PC_LO,
		SLOT_PC_HI,
		SLOT_FLAGS
	} wrsp_slot_t;

endpackage : wrsp_pkg

// File: hw/wrsp_ptr_step.sv
`timescale 1ns/10ps
module wrsp_ptr_step #(
	parameter int W = 16
) (
	input  wire logic [W-1:0] val_i,
	input  wire logic         inc_i,
	output logic      [W-1:0] val_o
);

	localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

	// Full-width step, carry or borrow runs through every byte
	assign val_o = inc_i ? (val_i + ONE) : (val_i - ONE);

endmodule : wrsp_ptr_step

// File: hw/wrsp_addr_form.sv
`timescale 1ns/10ps
module wrsp_addr_form (
	input  wire logic [7:0] wp0_i,
	input  wire logic [7:0] wp1_i,
	input  wire logic [7:0] opnd_i,
	input  wire logic       long_i,
	output logic      [7:0] addr_o
);

	logic [7:0] ptr;

	assign ptr = opnd_i[wrsp_pkg::SEL_BIT] ? wp1_i : wp0_i;

	always_comb begin
		if (long_i && (opnd_i[7:4] != wrsp_pkg::TAG_WORKING)) begin
			addr_o = opnd_i;
		end else begin
			addr_o = {ptr[7:wrsp_pkg::SLICE_LSB], opnd_i[2:0]};
		end
	end

endmodule : wrsp_addr_form

// File: verif/wrsp_rf_model.sv
`timescale 1ns/10ps
module wrsp_rf_model (
	input  wire logic        clk_i,
	input  wire logic        we_i,
	input  wire logic        re_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	output logic      [7:0]  rdata_o
);
	logic [7:0] mem [0:65535];
	logic [7:0] last_r = 8'h00;

	// Released bus shows inverse of last byte
	always_comb begin
		if (re_i) begin
			rdata_o = mem[addr_i];
		end else begin
			rdata_o = ~last_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[addr_i] <= wdata_i;
		end
		if (re_i) begin
			last_r <= rdata_o;
		end
	end
endmodule : wrsp_rf_model

// File: verif/wrsp_core_bench.sv
`timescale 1ns/10ps
module wrsp_core_bench;
	logic                clk_i = 1'b0, rst_i = 1'b1;
	logic                wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [9:0]          wb_adr_i = 10'h000;
	logic [3:0]          wb_sel_i = 4'h1, opnd_short_i = 4'h0;
	logic [31:0]         wb_dat_i = 32'h0, wb_dat_o;
	logic                wb_ack_o, rf_we_o, rf_re_o, stk_busy_o, stk_done_o;
	logic [7:0]          opnd_long_i = 8'h00, stk_data_i = 8'h00, flags_i = 8'h00, user_ptr_i = 8'h00;
	logic [7:0]          rf_rdata_i, short_addr_o, long_addr_o, rf_wdata_o, pop_data_o, flags_o, user_ptr_o;
	logic [15:0]         pc_i = 16'h0000, rf_addr_o, pc_o;
	wrsp_pkg::wrsp_cmd_t stk_cmd_i = wrsp_pkg::CMD_NONE;
	int                  bad_count = 0, n_compared = 0;

	always #25 clk_i = ~clk_i;

	wrsp_core DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .opnd_short_i(opnd_short_i),
		.opnd_long_i(opnd_long_i), .short_addr_o(short_addr_o), .long_addr_o(long_addr_o),
		.stk_cmd_i(stk_cmd_i), .stk_data_i(stk_data_i), .pc_i(pc_i), .flags_i(flags_i),
		.user_ptr_i(user_ptr_i), .rf_rdata_i(rf_rdata_i), .rf_we_o(rf_we_o), .rf_re_o(rf_re_o),
		.rf_addr_o(rf_addr_o), .rf_wdata_o(rf_wdata_o), .stk_busy_o(stk_busy_o),
		.stk_done_o(stk_done_o), .pop_data_o(pop_data_o), .pc_o(pc_o), .flags_o(flags_o),
		.user_ptr_o(user_ptr_o));

	wrsp_rf_model u_rf (.clk_i(clk_i), .we_i(rf_we_o), .re_i(rf_re_o), .addr_i(rf_addr_o),
		.wdata_i(rf_wdata_o), .rdata_o(rf_rdata_i));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] d,
		input logic [3:0] sel, output logic [7:0] q);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= sel;
		wb_dat_i <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			bad_count++;
			complete_run();
		end
	endtask : bus

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, idx, d, 4'h1, q);
	endtask : wr

	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] q;
		bus(1'b0, idx, 8'h00, 4'h1, q);
		check({8'h00, q}, {8'h00, exp}, "register read");
	endtask : rd

	task automatic addr_chk(input logic [3:0] s, input logic [7:0] l, input logic [7:0] es,
		input logic [7:0] el);
		@(posedge clk_i);
		opnd_short_i <= s;
		opnd_long_i  <= l;
		@(posedge clk_i);
		#1;
		check({8'h00, short_addr_o}, {8'h00, es}, "short address");
		check({8'h00, long_addr_o}, {8'h00, el}, "long address");
	endtask : addr_chk

	task automatic cmd(input wrsp_pkg::wrsp_cmd_t c);
		int n;
		@(posedge clk_i);
		stk_cmd_i <= c;
		@(posedge clk_i);
		stk_cmd_i <= wrsp_pkg::CMD_NONE;
		#1;
		check({15'h0000, stk_busy_o}, 16'h0001, "busy after accept");
		n = 0;
		while (stk_done_o !== 1'b1 && n < 20) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		if (stk_done_o !== 1'b1) begin
			bad_count++;
			complete_run();
		end
		check({15'h0000, stk_busy_o}, 16'h0000, "busy at done");
		repeat (2) @(posedge clk_i);
		#1;
	endtask : cmd

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_addr();
		rd(wrsp_pkg::IDX_WP0, wrsp_pkg::WP0_RST);
		rd(wrsp_pkg::IDX_WP1, wrsp_pkg::WP1_RST);
		rd(8'h10, 8'h00);
		addr_chk(4'h6, 8'h45, 8'hC6, 8'h45);
		wr(wrsp_pkg::IDX_WP0, 8'h70);
		wr(wrsp_pkg::IDX_WP1, 8'hA8);
		addr_chk(4'h6, 8'hCB, 8'h76, 8'hAB);
		addr_chk(4'hE, 8'hC2, 8'hAE, 8'h72);
		addr_chk(4'h0, 8'hD5, 8'h70, 8'hD5);
	endtask : t_addr

	task automatic t_push_pop();
		wr(wrsp_pkg::IDX_SPH, 8'h12);
		wr(wrsp_pkg::IDX_SPL, 8'h00);
		@(posedge clk_i);
		stk_data_i <= 8'h3C;
		cmd(wrsp_pkg::CMD_PUSH);
		check({8'h00, u_rf.mem[16'h11FF]}, 16'h003C, "pushed byte");
		rd(wrsp_pkg::IDX_SPH, 8'h11);
		rd(wrsp_pkg::IDX_SPL, 8'hFF);
		cmd(wrsp_pkg::CMD_POP);
		check({8'h00, pop_data_o}, 16'h003C, "popped byte");
		rd(wrsp_pkg::IDX_SPH, 8'h12);
		rd(wrsp_pkg::IDX_SPL, 8'h00);
	endtask : t_push_pop

	task automatic t_call_int();
		wr(wrsp_pkg::IDX_SPH, 8'h01);
		wr(wrsp_pkg::IDX_SPL, 8'h00);
		@(posedge clk_i);
		pc_i <= 16'hBEEF;
		flags_i <= 8'h5A;
		cmd(wrsp_pkg::CMD_CALL);
		check({u_rf.mem[16'h00FE], u_rf.mem[16'h00FF]}, 16'hBEEF, "saved counter");
		rd(wrsp_pkg::IDX_SPL, 8'hFE);
		pc_i <= 16'h0000;
		cmd(wrsp_pkg::CMD_RET);
		check(pc_o, 16'hBEEF, "restored counter");
		rd(wrsp_pkg::IDX_SPH, 8'h01);
		pc_i <= 16'h1234;
		cmd(wrsp_pkg::CMD_INT);
		check({8'h00, u_rf.mem[16'h00FD]}, 16'h005A, "saved flags");
		@(posedge clk_i);
		pc_i <= 16'h0000;
		flags_i <= 8'h00;
		cmd(wrsp_pkg::CMD_INTERRUPT_RETURN_INSTR);
		check({8'h00, flags_o}, 16'h005A, "restored flags");
		check(pc_o, 16'h1234, "restored counter");
	endtask : t_call_int

	task automatic t_user();
		wrsp_pkg::wrsp_cmd_t c [4] = '{wrsp_pkg::CMD_UPUSH_INC, wrsp_pkg::CMD_UPUSH_DEC,
			wrsp_pkg::CMD_UPOP_INC, wrsp_pkg::CMD_UPOP_DEC};
		logic [7:0] up [4] = '{8'h40, 8'h40, 8'h41, 8'h3F};
		logic [7:0] np [4] = '{8'h41, 8'h3F, 8'h42, 8'h3E};
		logic [7:0] ev [4] = '{8'hA0, 8'hA1, 8'hA0, 8'hA1};
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_i);
			user_ptr_i <= up[i];
			stk_data_i <= ev[i];
			cmd(c[i]);
			check({8'h00, user_ptr_o}, {8'h00, np[i]}, "user pointer");
			if (i < 2) begin
				check({8'h00, u_rf.mem[{8'h00, np[i]}]}, {8'h00, ev[i]}, "user push");
			end else begin
				check({8'h00, pop_data_o}, {8'h00, ev[i]}, "user pop");
			end
		end
	endtask : t_user

	task automatic t_reset();
		wr(wrsp_pkg::IDX_SPH, 8'h5A);
		wr(wrsp_pkg::IDX_SPL, 8'hFF);
		cmd(wrsp_pkg::CMD_PUSH);
		cmd(wrsp_pkg::CMD_POP);
		check({8'h00, pop_data_o}, 16'h00A1, "storage pop");
		rd(wrsp_pkg::IDX_SPH, 8'h5A);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(wrsp_pkg::IDX_WP0, wrsp_pkg::WP0_RST);
		rd(wrsp_pkg::IDX_WP1, wrsp_pkg::WP1_RST);
		rd(wrsp_pkg::IDX_SPH, 8'h5A);
		rd(wrsp_pkg::IDX_SPL, 8'hFF);
	endtask : t_reset

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_addr();
		t_push_pop();
		t_call_int();
		t_user();
		t_reset();
		complete_run();
	end
endmodule : wrsp_core_bench
